// >>> design/logic_program_interpreter.sv
/*
  sequencer that walks a stored numeric logic program one word per clock,
  keeps the one-bit intermediate result, reads the input pool, writes the
  output pool and fires actions.
  assumes the program store answers combinationally: prog_word belongs to
  the prog_addr of the same cycle. pools run on sys_clk, no synchronisers.
*/
// Functional notes
// R01 - every negative program word is decoded as an operator.
// R02 - positive words after an operator select one signal of a pool.
// R03 - inputs, outputs and actions are numbered apart; the operator picks.
// R04 - one intermediate result bit is read and updated by the operators.
// R05 - OR combines each following input into the intermediate result.
// R06 - AND combines the following inputs and puts the outcome in the result.
// R07 - STORE drives the named output to the intermediate result.
// R08 - LOAD copies the named input into the intermediate result.
// R09 - IF loads the first following input when true, else the second.
// R10 - CALL fires the named action with the intermediate result.
// R11 - INVERT flips the result, CLEAR forces false, SET forces true.
// R12 - NOP does nothing but a step; END restarts at the first step.
// R13 - steps run in ascending order; each pass starts with a false result.
`timescale 1ns/10ps
module logic_program_interpreter
  import plc_pkg::*;
#(
  parameter int PROG_DEPTH = 256,
  parameter int IN_COUNT = 128,
  parameter int OUT_COUNT = 70,
  parameter int ACT_COUNT = 16
) (
  // clock, reset, enables
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic run,
  // program store
  output logic [$clog2(PROG_DEPTH)-1:0] prog_addr,
  input wire logic [WORD_W-1:0] prog_word,
  // signal pools
  input wire logic [IN_COUNT-1:0] in_sig,
  output logic [OUT_COUNT-1:0] out_sig,
  output logic [ACT_COUNT-1:0] act_fire,
  output logic [ACT_COUNT-1:0] act_level,
  // status
  output logic intermediate_result,
  output logic pass_done
);

  localparam int ADDR_W = $clog2(PROG_DEPTH);
  localparam logic [ADDR_W-1:0] ADDR_FIRST = '0;
  localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(PROG_DEPTH - 1);
  localparam logic [ADDR_W-1:0] ADDR_INC = ADDR_W'(1);

  typedef struct packed {
    plc_state_t state;
    logic [ADDR_W-1:0] addr;
    logic ir;
    logic first;
    logic cond;
    logic hold;
    logic [ACT_COUNT-1:0] fire;
    logic [ACT_COUNT-1:0] level;
    logic done;
  } core_t;

  core_t cur;
  core_t next_cur;

  logic is_neg;
  logic is_pos;
  logic [ID_W-1:0] op_id;
  logic in_bit;
  logic in_valid;
  logic end_op;
  logic restart;
  logic step;
  logic wr_en;

  //////////////////////////////////////////////////////////////////////////
  // word classification
  assign is_neg = prog_word[SIGN_BIT]; // R01
  assign is_pos = !prog_word[SIGN_BIT] && (prog_word != '0); // R02
  assign op_id = prog_word[ID_W-1:0];
  assign step = ce && run;

  // the input pool is only ever read by input-class operators
  sig_select #(
    .N(IN_COUNT)
  ) u_in_sel (
    .pool(in_sig),
    .id(op_id),
    .sel(in_bit),
    .valid(in_valid)
  );

  // output pool writes only from the store operand state
  assign wr_en = step && is_pos && (cur.state == ST_STORE); // R03 R07

  out_bank #(
    .N(OUT_COUNT)
  ) u_out (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .wr_en(wr_en),
    .wr_id(op_id),
    .wr_val(cur.ir),
    .out_sig(out_sig)
  );

  //////////////////////////////////////////////////////////////////////////
  // next state; a negative word always decodes, even where an operand was
  // expected, so a short operand list never swallows the next operator
  always_comb begin
    next_cur = cur;
    next_cur.fire = '0;
    next_cur.done = 1'h0;
    end_op = 1'h0;
    restart = 1'h0;
    if (is_pos) begin
      case (cur.state)
        ST_OR: begin
          next_cur.ir = cur.ir | in_bit; // R05
        end
        ST_AND: begin
          next_cur.ir = cur.first ? in_bit : (cur.ir & in_bit); // R06
          next_cur.first = 1'h0;
        end
        ST_STORE: begin
          next_cur.state = ST_OP;
        end
        ST_LOAD: begin
          next_cur.ir = in_bit; // R08
          next_cur.state = ST_OP;
        end
        ST_IF1: begin
          next_cur.cond = cur.ir; // R09
          next_cur.hold = in_bit;
          next_cur.state = ST_IF2;
        end
        ST_IF2: begin
          next_cur.ir = cur.cond ? cur.hold : in_bit; // R09
          next_cur.state = ST_OP;
        end
        ST_CALL: begin
          for (int i = 0; i < ACT_COUNT; i++) begin
            if (op_id == ID_W'(i + 1)) begin
              next_cur.fire[i] = 1'h1; // R10
              next_cur.level[i] = cur.ir;
            end
          end
          next_cur.state = ST_OP;
        end
        ST_OP: begin
          next_cur.state = ST_OP;
        end
        default: begin
          next_cur.state = ST_OP;
        end
      endcase
    end else if (is_neg) begin
      next_cur.state = ST_OP; // R01 R03
      case (prog_word)
        OP_OR: next_cur.state = ST_OR;
        OP_AND: begin
          next_cur.state = ST_AND;
          next_cur.first = 1'h1;
        end
        OP_INVERT: next_cur.ir = !cur.ir; // R11
        OP_STORE: next_cur.state = ST_STORE;
        OP_CLEAR: next_cur.ir = IR_RESET; // R11
        OP_END: end_op = 1'h1; // R12
        OP_SET: next_cur.ir = IR_TRUE; // R11
        OP_LOAD: next_cur.state = ST_LOAD;
        OP_IF: next_cur.state = ST_IF1;
        OP_CALL: next_cur.state = ST_CALL;
        default: next_cur.state = ST_OP; // R12
      endcase
    end
    // running off the end of the store counts as an end of pass
    restart = end_op || (cur.addr == ADDR_LAST);
    if (restart) begin
      next_cur.addr = ADDR_FIRST; // R13
      next_cur.ir = IR_RESET; // R13
      next_cur.state = ST_OP;
      next_cur.done = 1'h1;
    end else begin
      next_cur.addr = cur.addr + ADDR_INC; // R13
    end
    // a stopped program keeps its place but drops its pulses; clock enable low holds pulses too
    if (!ce) begin
      next_cur = cur;
    end else if (!run) begin
      next_cur = cur;
      next_cur.fire = '0;
      next_cur.done = 1'h0;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '{state: ST_OP, addr: ADDR_FIRST, ir: IR_RESET, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  assign prog_addr = cur.addr;
  assign intermediate_result = cur.ir; // R04
  assign act_fire = cur.fire;
  assign act_level = cur.level;
  assign pass_done = cur.done;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // output index of the operand word, meaningful for ids 1..OUT_COUNT only
  localparam int OUT_W = $clog2(OUT_COUNT);
  logic [OUT_W-1:0] wr_idx;
  assign wr_idx = OUT_W'(op_id - ID_W'(1));

  // ids of zero or past the pool are dropped by the bank, so skip them here
  function automatic logic in_range_out(logic [ID_W-1:0] id);
    return id != '0 && id <= ID_W'(OUT_COUNT);
  endfunction

  restart_clear_a: assert property ( // R12
    step && end_op |=> cur.addr == ADDR_FIRST && cur.ir == IR_RESET
  ) else $error("end of program did not restart with false result");

  addr_ascend_a: assert property ( // R13
    step && !restart |=> cur.addr == $past(cur.addr) + ADDR_INC
  ) else $error("program step did not advance by one");

  or_combine_a: assert property ( // R05
    step && is_pos && cur.state == ST_OR
      |=> cur.ir == ($past(cur.ir) | $past(in_bit)) || $past(restart)
  ) else $error("or operand not combined into result");

  and_first_a: assert property ( // R06
    step && is_pos && cur.state == ST_AND && cur.first && !restart
      |=> cur.ir == $past(in_bit) && !cur.first
  ) else $error("first and operand not loaded");

  store_out_a: assert property ( // R07
    wr_en && in_range_out(op_id) |=> out_sig[$past(wr_idx)] == $past(cur.ir)
  ) else $error("stored output differs from result");

  load_copy_a: assert property ( // R08
    step && is_pos && cur.state == ST_LOAD && !restart
      |=> cur.ir == $past(in_bit) && cur.state == ST_OP
  ) else $error("load did not copy input");

  if_pick_a: assert property ( // R09
    step && is_pos && cur.state == ST_IF2 && !restart
      |=> cur.ir == ($past(cur.cond) ? $past(cur.hold) : $past(in_bit))
  ) else $error("if picked the wrong input");

  ir_invert_a: assert property ( // R11
    step && prog_word == OP_INVERT && !restart |=> cur.ir != $past(cur.ir)
  ) else $error("invert did not flip result");

  // result forcing operators and the idle step
  ir_clear_a: assert property ( // R11
    step && prog_word == OP_CLEAR |=> cur.ir == IR_RESET
  ) else $error("clear did not force the result false");

  ir_set_a: assert property ( // R11
    step && prog_word == OP_SET && !restart |=> cur.ir == IR_TRUE
  ) else $error("set did not force the result true");

  nop_keep_a: assert property ( // R12
    step && prog_word == OP_NOP && !restart
      |=> $stable(cur.ir) && $stable(out_sig) && act_fire == '0
  ) else $error("no-operation changed the result or outputs");

  pass_pulse_a: assert property ( // R13
    step && restart |=> pass_done && cur.addr == ADDR_FIRST
  ) else $error("end of pass not flagged at the first step");

  load_refused_a: assert property ( // R02
    step && is_pos && cur.state == ST_LOAD && !in_valid && !restart
      |=> cur.ir == IR_RESET
  ) else $error("load of an id outside the pool did not read low");

  call_fire_a: assert property ( // R10
    step && is_pos && cur.state == ST_CALL && op_id == ID_W'(1)
      |=> act_fire[0] && $onehot(act_fire) && act_level[0] == $past(cur.ir)
  ) else $error("call did not fire its action");

  ce_freeze_a: assert property (
    !ce |=> $stable(cur.addr) && $stable(cur.ir) && $stable(out_sig)
  ) else $error("state moved while clock enable low");

  pass_c: cover property (step && end_op);
  store_c: cover property (wr_en && cur.ir);
  call_c: cover property (|act_fire);
  if_c: cover property (step && is_pos && cur.state == ST_IF2 && !cur.cond);
  refused_c: cover property (step && is_pos && !in_valid);

endmodule // logic_program_interpreter

// >>> design/plc_pkg.sv
/*
  shared constants of the logic program interpreter: program word width,
  operator codes, reset values and the sequencer state encoding.
  assumes program words are two's complement, negative words are operators.
*/
package plc_pkg;

  // program word and operand identifier widths
  localparam int WORD_W = 16;
  localparam int ID_W = WORD_W - 1;

  // operator codes, two's complement of -1 .. -11
  localparam logic [WORD_W-1:0] OP_NOP = 16'hffff;
  localparam logic [WORD_W-1:0] OP_OR = 16'hfffe;
  localparam logic [WORD_W-1:0] OP_AND = 16'hfffd;
  localparam logic [WORD_W-1:0] OP_INVERT = 16'hfffc;
  localparam logic [WORD_W-1:0] OP_STORE = 16'hfffb;
  localparam logic [WORD_W-1:0] OP_CLEAR = 16'hfffa;
  localparam logic [WORD_W-1:0] OP_END = 16'hfff9;
  localparam logic [WORD_W-1:0] OP_SET = 16'hfff8;
  localparam logic [WORD_W-1:0] OP_LOAD = 16'hfff7;
  localparam logic [WORD_W-1:0] OP_IF = 16'hfff6;
  localparam logic [WORD_W-1:0] OP_CALL = 16'hfff5;

  // result values and the word sign bit position
  localparam logic IR_RESET = 1'h0;
  localparam logic IR_TRUE = 1'h1;
  localparam int SIGN_BIT = WORD_W - 1;

  // sequencer states
  typedef enum logic [3:0] {
    ST_OP = 4'h0,
    ST_OR = 4'h1,
    ST_AND = 4'h2,
    ST_STORE = 4'h3,
    ST_LOAD = 4'h4,
    ST_IF1 = 4'h5,
    ST_IF2 = 4'h6,
    ST_CALL = 4'h7
  } plc_state_t;

endpackage

// >>> design/sig_select.sv
/*
  picks one signal of a pool by its 1-based identifier.
  assumes the pool is driven from logic on the same clock; an identifier
  of zero or beyond the pool reads as low and reports not valid.
*/
`timescale 1ns/10ps
module sig_select
  import plc_pkg::*;
#(
  parameter int N = 128
) (
  // pool and selection
  input wire logic [N-1:0] pool,
  input wire logic [ID_W-1:0] id,
  // answer
  output logic sel,
  output logic valid
);

  logic [N-1:0] hit;
  logic [N-1:0] match;

  //////////////////////////////////////////////////////////////////////////
  // one comparator per pool entry keeps the mux free of subtraction
  for (genvar g = 0; g < N; g++) begin : g_entry
    assign match[g] = (id == ID_W'(g + 1)); // R02
    assign hit[g] = match[g] & pool[g];
  end

  assign sel = |hit;
  assign valid = |match;

endmodule // sig_select

// >>> design/out_bank.sv
/*
  the output signal pool: one held bit per identifier.
  assumes the writer gates its write strobe with the clock enable;
  writes to identifiers outside the pool are dropped.
*/
`timescale 1ns/10ps
module out_bank
  import plc_pkg::*;
#(
  parameter int N = 70
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // write port
  input wire logic wr_en,
  input wire logic [ID_W-1:0] wr_id,
  input wire logic wr_val,
  // pool contents
  output logic [N-1:0] out_sig
);

  typedef struct packed {
    logic [N-1:0] bits;
  } bank_t;

  bank_t cur;
  bank_t next_cur;

  //////////////////////////////////////////////////////////////////////////
  // per-entry write decode, one entry at most changes per cycle
  always_comb begin
    next_cur = cur;
    for (int i = 0; i < N; i++) begin
      if (wr_en && wr_id == ID_W'(i + 1)) begin
        next_cur.bits[i] = wr_val; // R07
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign out_sig = cur.bits;

endmodule // out_bank

// >>> verification/prog_store.sv
/*
  behavioural program store standing beside the interpreter.
  assumes the bench fills mem by hierarchical write while the
  interpreter is held in reset; reads are combinational.
*/
`timescale 1ns/10ps
module prog_store
  import plc_pkg::*;
#(
  parameter int DEPTH = 32
) (
  // read port
  input wire logic [$clog2(DEPTH)-1:0] addr,
  output logic [WORD_W-1:0] word
);
  logic [WORD_W-1:0] mem [DEPTH];

  // same-cycle answer, as the sequencer expects no wait state
  assign word = mem[addr];
endmodule // prog_store

// >>> verification/tb.sv
/*
  self-checking bench of the logic program interpreter.
  assumes the program store model answers combinationally and the
  bench owns the input pool; inputs change on the falling edge.
*/
`timescale 1ns/10ps
module tb
  import plc_pkg::*;
;
  localparam int DEPTH = 32;

  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic run = 1'b0;
  logic [$clog2(DEPTH)-1:0] prog_addr;
  logic [WORD_W-1:0] prog_word;
  logic [127:0] in_sig = '0;
  logic [69:0] out_sig;
  logic [15:0] act_fire;
  logic [15:0] act_level;
  logic [15:0] fired;
  logic intermediate_result;
  logic pass_done;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int steps;

  logic_program_interpreter #(.PROG_DEPTH(DEPTH)) u_dut (
    .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .run(run),
    .prog_addr(prog_addr), .prog_word(prog_word), .in_sig(in_sig),
    .out_sig(out_sig), .act_fire(act_fire), .act_level(act_level),
    .intermediate_result(intermediate_result), .pass_done(pass_done)
  );

  prog_store #(.DEPTH(DEPTH)) u_store (.addr(prog_addr), .word(prog_word));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  //////////////////////////////////////////////////////////////////////
  // helpers

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // reset held two cycles while the program is written
  task automatic load(int w[$]);
    @(negedge sys_clk);
    nrst = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      u_store.mem[i] = (i < w.size()) ? w[i][15:0] : OP_END;
    end
    repeat (2) @(negedge sys_clk);
    nrst = 1'b1;
  endtask

  // bounded run: collects action pulses, counts steps across all passes
  task automatic go(int passes);
    steps = 0;
    fired = '0;
    run = 1'b1;
    while (passes > 0 && steps < 200) begin
      @(negedge sys_clk);
      steps++;
      fired = fired | act_fire;
      if (pass_done === 1'b1) begin
        passes--;
      end
    end
    run = 1'b0;
    chk("pass reached", 0, passes);
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios

  task automatic t_walk();
    in_sig = '0;
    in_sig[44] = 1'b1;
    load('{-2, 65, 66, 45, -5, 1, -7});
    go(1);
    chk("walk steps", 7, steps);
    chk("walk out1", 1, out_sig[0]);
    chk("walk ir", 0, intermediate_result);
    chk("walk addr", 0, prog_addr);
  endtask

  task automatic t_and();
    in_sig = '0;
    in_sig[0] = 1'b1;
    load('{-8, -5, 2, -3, 1, 2, -5, 2, -3, 1, -5, 3, -1, -7});
    go(1);
    chk("and out2", 0, out_sig[1]);
    chk("and out3", 1, out_sig[2]);
    chk("and steps", 14, steps);
  endtask

  task automatic t_ops();
    in_sig = '0;
    in_sig[3] = 1'b1;
    in_sig[5] = 1'b1;
    load('{-6, -4, -5, 3, -9, 5, -4, -5, 4, -8, -10, 5, 6, -10, 5, 6,
           -5, 8, -11, 2, -1, -7});
    go(1);
    chk("ops out3", 1, out_sig[2]);
    chk("ops out4", 1, out_sig[3]);
    chk("ops out8", 1, out_sig[7]);
    chk("ops fire", 16'h0002, fired);
    chk("ops level", 16'h0002, act_level);
  endtask

  // a stale true result would leak into the second pass
  task automatic t_restart();
    in_sig = '0;
    load('{-2, 9, -5, 9, -8, -7});
    go(2);
    chk("restart out9", 0, out_sig[8]);
    chk("restart steps", 12, steps);
  endtask

  // words outside any operand slot and a negative word in a slot;
  // an id past the pool must read low, not alias onto a low id
  task automatic t_stray();
    in_sig = '0;
    in_sig[1] = 1'b1;
    in_sig[71] = 1'b1;
    load('{7, -9, -8, -5, 6, 3, -9, 2, -5, 10, -8, -9, 200, -5, 11, -7});
    go(1);
    chk("stray out6", 1, out_sig[5]);
    chk("stray out10", 1, out_sig[9]);
    chk("stray in pool", 0, out_sig[1]);
    chk("stray refused", 0, out_sig[10]);
  endtask

  // clock enable low freezes everything, run low only parks the program
  task automatic t_hold();
    in_sig = '0;
    load('{-8, -11, 3, -5, 12, -7});
    run = 1'b1;
    repeat (3) @(negedge sys_clk);
    ce = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk("hold addr", 3, prog_addr);
    chk("hold fire", 16'h0004, act_fire);
    ce = 1'b1;
    run = 1'b0;
    @(negedge sys_clk);
    chk("park addr", 3, prog_addr);
    chk("park fire", 0, act_fire);
    chk("park ir", 1, intermediate_result);
    go(1);
    chk("hold out12", 1, out_sig[11]);
    chk("hold level", 16'h0004, act_level);
  endtask

  //////////////////////////////////////////////////////////////////////
  // run control

  task automatic conclude();
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    repeat (2) @(negedge sys_clk);
    t_walk();
    t_and();
    t_ops();
    t_restart();
    t_stray();
    t_hold();
    conclude();
  end
endmodule // tb
